/* pkg/fcr_defines.vh */
// Constants for the flash command host controller
`ifndef FCR_DEFINES_VH
`define FCR_DEFINES_VH
// Command codes
`define FCR_CMD_PROG_ALT 8'h10
`define FCR_CMD_ERASE_SETUP 8'h20
`define FCR_CMD_PROG_SETUP 8'h40
`define FCR_CMD_CLR_STATUS 8'h50
`define FCR_CMD_READ_STATUS 8'h70
`define FCR_CMD_IDENT 8'h90
`define FCR_CMD_SUSPEND 8'hb0
`define FCR_CMD_CONFIRM 8'hd0
`define FCR_CMD_READ_ARRAY 8'hff
// User operation codes
`define FCR_OP_READ 3'h0
`define FCR_OP_READ_ARRAY 3'h1
`define FCR_OP_IDENT 3'h2
`define FCR_OP_STATUS 3'h3
`define FCR_OP_CLR_STATUS 3'h4
`define FCR_OP_PROGRAM 3'h5
`define FCR_OP_ERASE 3'h6
`define FCR_OP_SUSPEND 3'h7
// Status bit positions
`define FCR_SR_READY 7
`define FCR_SR_ERASE_ERR 5
`define FCR_SR_PROG_ERR 4
// Read modes the device is believed to be in
`define FCR_MODE_ARRAY 2'h0
`define FCR_MODE_IDENT 2'h1
`define FCR_MODE_STATUS 2'h2
// Bus cycle timing in ns and derived clock counts at 250 MHz (4 ns)
`define FCR_CLK_NS 4
`define FCR_T_ACCESS_NS 80
`define FCR_T_WRITE_NS 40
`define FCR_T_RECOVER_NS 20
`define FCR_ACC_CYC ((`FCR_T_ACCESS_NS + `FCR_CLK_NS - 1) / `FCR_CLK_NS)
`define FCR_WR_CYC ((`FCR_T_WRITE_NS + `FCR_CLK_NS - 1) / `FCR_CLK_NS)
`define FCR_REC_CYC ((`FCR_T_RECOVER_NS + `FCR_CLK_NS - 1) / `FCR_CLK_NS)
`define FCR_WAIT_W 6
`endif

/* hw/fcr_bus_cycle.v */
// One asynchronous bus cycle (read or write) on the flash pins
`timescale 1ns/10ps
`include "fcr_defines.vh"
module fcr_bus_cycle (
	input wire clk,
	input wire rst,
	input wire start,
	input wire wr,
	input wire [18:0] addr,
	input wire [15:0] wdata,
	input wire [15:0] dq_i,
	output wire done,
	output reg [15:0] rdata_q,
	output reg [18:0] addr_q,
	output reg [15:0] dq_o_q,
	output reg dq_oe_q,
	output reg ce_n_q,
	output reg oe_n_q,
	output reg we_n_q
);
	localparam S_IDLE = 2'd0;
	localparam S_ACT = 2'd1;
	localparam S_REC = 2'd2;
	localparam S_DONE = 2'd3;
	// Load values cut to the counter width on purpose; every figure fits in it
	localparam [31:0] WR_CNT = `FCR_WR_CYC;
	localparam [31:0] RD_CNT = `FCR_ACC_CYC + 2;
	localparam [31:0] REC_CNT = `FCR_REC_CYC;
	reg [1:0] st_q;
	reg [`FCR_WAIT_W-1:0] cnt_q;
	reg wr_q;
	reg [15:0] dq_s1_q;
	reg [15:0] dq_s2_q;

	// Data pins come from outside the clock domain
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
		end else begin
			dq_s1_q <= dq_i;
			dq_s2_q <= dq_s1_q;
		end
	end

	assign done = (st_q == S_DONE);

	// Strobe sequencer; we_n is only low with oe_n high, so no bus fight
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= S_IDLE;
			cnt_q <= {`FCR_WAIT_W{1'b0}};
			wr_q <= 1'b0;
			rdata_q <= 16'h0000;
			addr_q <= 19'h00000;
			dq_o_q <= 16'h0000;
			dq_oe_q <= 1'b0;
			ce_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
		end else begin
			case (st_q)
			S_IDLE: begin
				if (start) begin
					st_q <= S_ACT;
					wr_q <= wr;
					addr_q <= addr;
					dq_o_q <= wdata;
					dq_oe_q <= wr; // [R04]
					ce_n_q <= 1'b0;
					oe_n_q <= wr;
					we_n_q <= ~wr; // [R02]
					cnt_q <= wr ? WR_CNT[`FCR_WAIT_W-1:0] : RD_CNT[`FCR_WAIT_W-1:0];
				end
			end
			S_ACT: begin
				if (cnt_q == {`FCR_WAIT_W{1'b0}}) begin
					// Two extra cycles cover the synchroniser delay on reads
					if (!wr_q)
						rdata_q <= dq_s2_q;
					ce_n_q <= 1'b1;
					oe_n_q <= 1'b1;
					we_n_q <= 1'b1;
					st_q <= S_REC;
					cnt_q <= REC_CNT[`FCR_WAIT_W-1:0];
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end
			S_REC: begin
				dq_oe_q <= 1'b0;
				if (cnt_q == {`FCR_WAIT_W{1'b0}})
					st_q <= S_DONE;
				else
					cnt_q <= cnt_q - 1'b1;
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule

/* hw/fcr_host.v */
// Host controller that issues command sequences to the boot flash
`timescale 1ns/10ps
`include "fcr_defines.vh"
// Contract
// (R01) After reset release the flash reads array with no command.
// (R02) Array read: write strobe high, chip and output enable low, address given.
// (R03) Outside array mode, write read-array code before expecting array data.
// (R04) Data pins driven only during writes; released when output enable falls.
// (R05) Identifier command: address bit zero selects maker or part code.
// (R06) Identifier mode decodes only address bit zero.
// (R07) Byte mode returns only the low identifier byte.
// (R08) Write read-array to leave identifier mode.
// (R09) Command bytes 10,20,40,50,70,90,b0,d0,ff as listed.
// (R10) Never write reserved or unassigned codes, including 00.
// (R11) While busy only status reads, plus suspend during erase.
// (R12) Machine-status bit set at completion re-enables all commands.
// (R13) Decoder keeps its command state until a new command.
// (R14) Read after a started two-write sequence returns status.
// (R15) Read-array after erase setup cancels the setup.
// (R16) After program setup write read-array twice to return to array.
// (R17) After read-status every read returns status regardless of address.
// (R18) Completion of program or erase switches to status reads.
// (R19) Error bits accumulate until the clear-status command.
// (R20) Program setup, either code, arms the next write as address and data.
// (R21) Second write latches and starts programming; reads give status.
// (R22) Erase: setup then confirm, both carrying a block address.
// (R23) Non-confirm after erase setup sets both error bits, status mode.
// (R24) Status on low byte; upper byte zero in word mode.
module fcr_host (
	input wire clk,
	input wire rst,
	input wire req_valid,
	output wire req_ready,
	input wire [2:0] req_op,
	input wire [18:0] req_addr,
	input wire [15:0] req_data,
	input wire byte_mode,
	output reg resp_valid_q,
	output reg [15:0] resp_data_q,
	output reg [1:0] read_mode_q,
	output reg busy_q,
	output reg [18:0] flash_addr,
	output reg [15:0] flash_dq_o,
	output reg flash_dq_oe,
	input wire [15:0] flash_dq_i,
	output reg ce_n,
	output reg oe_n,
	output reg we_n,
	output reg byte_n,
	output reg reset_powerdown_n
);
	localparam H_RESET = 3'd0;
	localparam H_IDLE = 3'd1;
	localparam H_CMD1 = 3'd2;
	localparam H_CMD2 = 3'd3;
	localparam H_READ = 3'd4;
	localparam H_POLL = 3'd5;

	reg [2:0] st_q;
	reg [2:0] op_q;
	reg [18:0] a_q;
	reg [15:0] d_q;
	reg bc_start;
	reg bc_wr;
	reg [18:0] bc_addr;
	reg [15:0] bc_wdata;
	wire bc_done;
	wire [15:0] bc_rdata;
	wire [18:0] pin_addr;
	wire [15:0] pin_dq_o;
	wire pin_dq_oe;
	wire pin_ce_n;
	wire pin_oe_n;
	wire pin_we_n;

	// First command byte of each operation; only defined codes are ever sent
	function [7:0] first_cmd;
		input [2:0] op;
		begin
			case (op)
			`FCR_OP_IDENT: first_cmd = `FCR_CMD_IDENT; // [R05] [R09]
			`FCR_OP_STATUS: first_cmd = `FCR_CMD_READ_STATUS; // [R17]
			`FCR_OP_CLR_STATUS: first_cmd = `FCR_CMD_CLR_STATUS; // [R19]
			`FCR_OP_PROGRAM: first_cmd = `FCR_CMD_PROG_SETUP; // [R20]
			`FCR_OP_ERASE: first_cmd = `FCR_CMD_ERASE_SETUP; // [R22]
			`FCR_OP_SUSPEND: first_cmd = `FCR_CMD_SUSPEND;
			default: first_cmd = `FCR_CMD_READ_ARRAY; // [R03] [R08] [R10]
			endcase
		end
	endfunction

	// Whether the device would accept this operation while its machine runs; suspend passes during program as well as erase
	function op_legal_busy;
		input [2:0] op;
		begin
			op_legal_busy = (op == `FCR_OP_STATUS) || (op == `FCR_OP_READ)
				|| (op == `FCR_OP_SUSPEND); // [R11]
		end
	endfunction

	fcr_bus_cycle u_cycle (
		.clk(clk),
		.rst(rst),
		.start(bc_start),
		.wr(bc_wr),
		.addr(bc_addr),
		.wdata(bc_wdata),
		.dq_i(flash_dq_i),
		.done(bc_done),
		.rdata_q(bc_rdata),
		.addr_q(pin_addr),
		.dq_o_q(pin_dq_o),
		.dq_oe_q(pin_dq_oe),
		.ce_n_q(pin_ce_n),
		.oe_n_q(pin_oe_n),
		.we_n_q(pin_we_n)
	);

	// Pins come straight from the cycle engine's flops
	always @* begin
		flash_addr = pin_addr;
		flash_dq_o = pin_dq_o;
		flash_dq_oe = pin_dq_oe; // [R04]
		ce_n = pin_ce_n;
		oe_n = pin_oe_n;
		we_n = pin_we_n;
	end

	// Busy operations that the device would ignore are held off here
	assign req_ready = (st_q == H_IDLE) && !(busy_q && !op_legal_busy(req_op));

	// Cycle engine request for the current state
	always @* begin
		bc_start = 1'b0;
		bc_wr = 1'b0;
		bc_addr = a_q;
		bc_wdata = {8'h00, first_cmd(op_q)};
		case (st_q)
		H_CMD1: bc_start = 1'b1;
		H_CMD2: begin
			bc_start = 1'b1;
			bc_wr = 1'b1;
			// Program data or erase confirm, same address as the setup write
			if (op_q == `FCR_OP_PROGRAM)
				bc_wdata = d_q; // [R21]
			else if (op_q == `FCR_OP_ERASE)
				bc_wdata = {8'h00, `FCR_CMD_CONFIRM}; // [R22]
			else
				bc_wdata = {8'h00, `FCR_CMD_READ_ARRAY}; // [R16]
		end
		H_READ, H_POLL: bc_start = 1'b1;
		default: bc_start = 1'b0;
		endcase
		if (st_q == H_CMD1)
			bc_wr = 1'b1;
		if (st_q == H_READ && read_mode_q == `FCR_MODE_IDENT)
			bc_addr = {18'h00000, a_q[0]}; // [R06]
	end

	// Sequencer; bc_start is held, the engine takes it only when idle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= H_RESET;
			op_q <= `FCR_OP_READ;
			a_q <= 19'h00000;
			d_q <= 16'h0000;
			resp_valid_q <= 1'b0;
			resp_data_q <= 16'h0000;
			read_mode_q <= `FCR_MODE_ARRAY;
			busy_q <= 1'b0;
			byte_n <= 1'b1;
			reset_powerdown_n <= 1'b0;
		end else begin
			resp_valid_q <= 1'b0;
			case (st_q)
			H_RESET: begin
				reset_powerdown_n <= 1'b1;
				read_mode_q <= `FCR_MODE_ARRAY; // [R01]
				st_q <= H_IDLE;
			end
			H_IDLE: begin
				byte_n <= ~byte_mode; // [R02]
				if (req_valid && req_ready) begin
					op_q <= req_op;
					a_q <= req_addr;
					d_q <= req_data;
					// Plain reads skip the command write [R13]
					st_q <= (req_op == `FCR_OP_READ) ? H_READ : H_CMD1;
				end
			end
			H_CMD1: if (bc_done) begin
				case (op_q)
				`FCR_OP_READ_ARRAY: begin
					read_mode_q <= `FCR_MODE_ARRAY; // [R15]
					resp_valid_q <= 1'b1;
					st_q <= H_IDLE;
				end
				`FCR_OP_IDENT: begin
					read_mode_q <= `FCR_MODE_IDENT;
					st_q <= H_READ;
				end
				`FCR_OP_STATUS: begin
					read_mode_q <= `FCR_MODE_STATUS;
					st_q <= H_READ;
				end
				`FCR_OP_PROGRAM, `FCR_OP_ERASE: begin
					read_mode_q <= `FCR_MODE_STATUS; // [R20]
					st_q <= H_CMD2;
				end
				default: begin
					resp_valid_q <= 1'b1;
					st_q <= H_IDLE;
				end
				endcase
			end
			H_CMD2: if (bc_done) begin
				busy_q <= 1'b1;
				st_q <= H_POLL; // [R14]
			end
			H_READ: if (bc_done) begin
				resp_valid_q <= 1'b1;
				st_q <= H_IDLE;
				if (read_mode_q == `FCR_MODE_STATUS)
					resp_data_q <= {8'h00, bc_rdata[7:0]}; // [R24]
				else if (read_mode_q == `FCR_MODE_IDENT && !byte_n)
					resp_data_q <= {8'h00, bc_rdata[7:0]}; // [R07]
				else
					resp_data_q <= byte_n ? bc_rdata : {8'h00, bc_rdata[7:0]};
			end
			H_POLL: if (bc_done) begin
				// Each poll is a fresh strobe so the status latch refreshes
				if (bc_rdata[`FCR_SR_READY]) begin
					busy_q <= 1'b0; // [R12]
					read_mode_q <= `FCR_MODE_STATUS; // [R18]
					resp_data_q <= {8'h00, bc_rdata[7:0]}; // [R23]
					resp_valid_q <= 1'b1;
					st_q <= H_IDLE;
				end
			end
			default: st_q <= H_IDLE;
			endcase
		end
	end
endmodule

/* testbench/fcr_host_checker.sv */
// Pin protocol checker for the flash host controller
`timescale 1ns/10ps
module fcr_host_checker (
	input wire clk,
	input wire rst,
	input wire [18:0] flash_addr,
	input wire [15:0] flash_dq_o,
	input wire flash_dq_oe,
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire reset_powerdown_n,
	input wire [1:0] read_mode_q
);
	reg we_q;
	reg [7:0] cur_q, last_q, prev_q;
	reg [18:0] ca_q, la_q;
	// Shifted once per strobe, so two-write sequences can be judged
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			{we_q, cur_q, last_q, prev_q, ca_q, la_q} <= {1'b1, 62'h0};
		end else begin
			we_q <= we_n;
			if (!we_n) {cur_q, ca_q} <= {flash_dq_o[7:0], flash_addr};
			if (we_n && !we_q) {prev_q, last_q, la_q} <= {last_q, cur_q, ca_q};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wr_end; we_n && !we_q; endsequence
	sequence s_to_array; $changed(read_mode_q) && read_mode_q == 2'h0; endsequence
	a_read_ctl: assert property (!oe_n |-> we_n && !ce_n && reset_powerdown_n)
		else $error("bad read controls");
	a_write_ctl: assert property (!we_n |-> oe_n && !ce_n && flash_dq_oe)
		else $error("bad write controls");
	a_write_hold: assert property ($fell(we_n) |=> (!we_n && $stable(flash_addr)) [*7])
		else $error("write pulse too short");
	a_cmd_defined: assert property (s_wr_end ##0 (last_q != 8'h40 && last_q != 8'h10)
		|-> cur_q != 8'h00) else $error("null command");
	a_erase_addr: assert property (s_wr_end ##0 (cur_q == 8'hd0 && last_q == 8'h20)
		|-> ca_q == la_q) else $error("erase address moved");
	a_array_cmd: assert property (s_to_array |-> last_q == 8'hff)
		else $error("array mode without command");
	a_prog_abort: assert property (s_to_array |-> prev_q != 8'h40 && prev_q != 8'h10)
		else $error("program setup left early");
endmodule

/* testbench/fcr_flash_model.sv */
// Behavioural boot flash device on the far side of the controller
`timescale 1ns/10ps
module fcr_flash_model #(
	parameter [15:0] MAKER = 16'h00a1, // Arbitrary
	parameter [15:0] PART = 16'h00b2, // Arbitrary
	parameter BUSY_NS = 2000
) (
	input wire [18:0] flash_addr,
	input wire [15:0] flash_dq_o,
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire byte_n,
	input wire reset_powerdown_n,
	output wire [15:0] flash_dq_i
);
	reg [15:0] mem [0:15];
	reg [15:0] rd, last;
	reg [7:0] sr;
	reg [1:0] mode;
	reg ps, es;
	realtime done_t;
	integer i;
	wire [3:0] a = flash_addr[3:0];
	wire [7:0] d = flash_dq_o[7:0];
	initial begin
		last = 16'h0000;
		for (i = 0; i < 16; i = i + 1) mem[i] = 16'hffff;
	end
	// Commands act on the rising write strobe; while busy only status is heard
	always @(negedge reset_powerdown_n or posedge we_n) begin
		if (!reset_powerdown_n) begin
			{mode, ps, es, sr} = {4'h0, 8'h80};
			done_t = 0;
		end else if ($realtime < done_t) begin
			if (d == 8'h70) mode = 2'h2;
		end else if (ps) begin
			mem[a] = mem[a] & flash_dq_o;
			{ps, mode} = 3'h2;
			done_t = $realtime + BUSY_NS;
		end else if (es) begin
			es = 0;
			mode = (d == 8'hff) ? 2'h0 : 2'h2;
			if (d == 8'hd0) begin
				for (i = 0; i < 16; i = i + 1) mem[i] = 16'hffff;
				done_t = $realtime + BUSY_NS;
			end else if (d != 8'hff) sr = sr | 8'h30;
		end else begin
			case (d)
				8'h10, 8'h40: {ps, mode} = 3'h6;
				8'h20: es = 1;
				8'h50: sr = sr & 8'hc7;
				8'h70: mode = 2'h2;
				8'h90: mode = 2'h1;
				8'hff: mode = 2'h0;
				default: ;
			endcase
		end
	end
	// Read data picked as the strobes fall, which also latches status
	always @(negedge oe_n or negedge ce_n) begin
		sr[7] = $realtime >= done_t;
		case (mode)
			2'h0: rd = mem[a];
			2'h1: rd = flash_addr[0] ? PART : MAKER;
			default: rd = {8'h00, sr};
		endcase
		if (!byte_n) rd[15:8] = ~last[15:8]; // upper lines float
	end
	always @(posedge oe_n) last = rd;
	// A released bus shows the inverse of the last word, never a kind value
	assign flash_dq_i = (!ce_n && !oe_n && reset_powerdown_n) ? rd : ~last;
endmodule

/* testbench/fcr_host_tb.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/10ps
module fcr_host_tb;
	localparam [15:0] MAKER = 16'h00a1; // Arbitrary
	localparam [15:0] PART = 16'h00b2; // Arbitrary
	reg clk = 0, rst = 1, req_valid = 0, byte_mode = 0;
	reg [2:0] req_op = 0;
	reg [18:0] req_addr = 0;
	reg [15:0] req_data = 0;
	wire req_ready, resp_valid_q, busy_q, flash_dq_oe, ce_n, oe_n, we_n, byte_n;
	wire reset_powerdown_n;
	wire [15:0] resp_data_q, flash_dq_o, flash_dq_i;
	wire [1:0] read_mode_q;
	wire [18:0] flash_addr;
	integer fails = 0, cmp_count = 0;
	always #2 clk = ~clk;
	fcr_host i_dut (.clk, .rst, .req_valid, .req_ready, .req_op, .req_addr, .req_data,
		.byte_mode, .resp_valid_q, .resp_data_q, .read_mode_q, .busy_q, .flash_addr,
		.flash_dq_o, .flash_dq_oe, .flash_dq_i, .ce_n, .oe_n, .we_n, .byte_n,
		.reset_powerdown_n);
	fcr_flash_model #(.MAKER(MAKER), .PART(PART)) i_flash (.flash_addr, .flash_dq_o,
		.ce_n, .oe_n, .we_n, .byte_n, .reset_powerdown_n, .flash_dq_i);
	task chk(input [15:0] exp, input [15:0] got);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
			end
		end
	endtask
	// One request, held until taken, then a bounded wait for its answer
	task op(input [2:0] o, input [18:0] a, input [15:0] d);
		integer n;
		begin
			{req_op, req_addr, req_data, req_valid} = {o, a, d, 1'b1};
			n = 0;
			while (req_ready !== 1'b1 && n < 99) begin
				@(negedge clk);
				n = n + 1;
			end
			@(negedge clk);
			req_valid = 0;
			while (resp_valid_q !== 1'b1 && n < 20000) begin
				@(negedge clk);
				n = n + 1;
			end
			if (n >= 20000) fails = fails + 1;
		end
	endtask
	task t_ident;
		begin
			op(2, 19'h0, 0);
			chk(MAKER, resp_data_q);
			op(2, 19'h7ffff, 0);
			chk(PART, resp_data_q);
			byte_mode = 1;
			op(2, 19'h1, 0);
			chk({8'h00, PART[7:0]}, resp_data_q);
			byte_mode = 0;
			op(1, 19'h0, 0);
			chk(16'h0000, {14'h0, read_mode_q});
		end
	endtask
	task t_prog;
		begin
			op(5, 19'h5, 16'h1234);
			chk(16'h0080, resp_data_q);
			chk(16'h0000, {15'h0000, busy_q});
			op(0, 19'h5, 0);
			chk(16'h0080, resp_data_q);
			op(1, 19'h0, 0);
			op(0, 19'h5, 0);
			chk(16'h1234, resp_data_q);
		end
	endtask
	task t_erase;
		begin
			op(6, 19'h5, 0);
			chk(16'h0080, resp_data_q);
			op(3, 19'h2, 0);
			chk(16'h0080, resp_data_q);
			op(1, 19'h0, 0);
			op(0, 19'h5, 0);
			chk(16'hffff, resp_data_q);
		end
	endtask
	task t_misc;
		begin
			op(4, 19'h0, 0);
			op(7, 19'h0, 0);
			op(3, 19'h0, 0);
			chk(16'h0080, resp_data_q);
			byte_mode = 1;
			op(1, 19'h0, 0);
			op(0, 19'h5, 0);
			chk(16'h00ff, resp_data_q);
		end
	endtask
	task wrap_up;
		begin
			$display("compares %0d mismatches %0d", cmp_count, fails);
			if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
			else $display("*** FAIL ***");
			$finish;
		end
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst = 0;
		@(negedge clk);
		op(0, 19'h3, 0);
		chk(16'hffff, resp_data_q);
		t_ident;
		t_prog;
		t_erase;
		t_misc;
		wrap_up;
	end
	// A hang is cut short; a clean run needs under two thousand cycles, this is 15000
	initial begin
		#60000;
		fails = fails + 1;
		wrap_up;
	end
endmodule
bind fcr_host fcr_host_checker i_chk (.clk, .rst, .flash_addr, .flash_dq_o, .flash_dq_oe,
	.ce_n, .oe_n, .we_n, .reset_powerdown_n, .read_mode_q);
